// ---- sim/picond_pad_model.sv ----
// pad model: turns a per-pin voltage in percent of supply into comparator taps
`timescale 1ns/10ps

module picond_pad_model #(
  parameter int TTL_PCT  = 28,  // 1.4 v on a 5 v supply
  parameter int CMOS_PCT = 50,  // half supply
  parameter int HI_PCT   = 85,  // upper hysteresis threshold
  parameter int LO_PCT   = 15   // lower hysteresis threshold
) (
  input  wire logic [picond_pkg::NPIN-1:0][6:0] volt_i,    // pin voltage, percent of supply
  output logic      [picond_pkg::NPIN-1:0]      cmp_ttl_o,  // above ttl threshold
  output logic      [picond_pkg::NPIN-1:0]      cmp_cmos_o, // above half supply
  output logic      [picond_pkg::NPIN-1:0]      cmp_hi_o,   // above upper threshold
  output logic      [picond_pkg::NPIN-1:0]      cmp_lo_o    // above lower threshold
);
  // comparators are asynchronous, so the taps follow the voltage with no clock
  always_comb begin
    for (int i = 0; i < picond_pkg::NPIN; i++) begin
      cmp_ttl_o[i]  = int'(volt_i[i]) > TTL_PCT;
      cmp_cmos_o[i] = int'(volt_i[i]) > CMOS_PCT;
      cmp_hi_o[i]   = int'(volt_i[i]) > HI_PCT;
      cmp_lo_o[i]   = int'(volt_i[i]) > LO_PCT;
    end
  end
endmodule

// ---- sim/tb.sv ----
// self-checking testbench for the port input conditioning block
`timescale 1ns/10ps

module tb;
  logic                                    core_clk_i = 1'b0;
  logic                                    rst_i = 1'b1;
  logic                                    mode_wr_i = 1'b0;
  logic [3:0]                              mode_val_i = 4'h0;
  logic                                    cfg_wr_i = 1'b0;
  logic [2:0]                              cfg_port_i = 3'h0;
  logic [7:0]                              cfg_data_i = 8'h00;
  logic [picond_pkg::NPIN-1:0][6:0]        volt = '0;
  logic [picond_pkg::NPIN-1:0]             c_ttl, c_cmos, c_hi, c_lo;
  logic [3:0]                              mode_o;
  logic [picond_pkg::NPIN-1:0]             dir_o, level_sel_o, hyst_sel_o, pin_val_o;
  logic [7:0]                              edge_pol_o, wakeup_en_o, edge_pend_o, swap_data_o;
  logic                                    swap_valid_o, wake_req_o;
  int                                      mismatches = 0;
  int                                      comparisons = 0;

  // 25 mhz system clock
  always #20 core_clk_i = ~core_clk_i;

  picond_pad_model i_picond_pad_model (
    .volt_i(volt), .cmp_ttl_o(c_ttl), .cmp_cmos_o(c_cmos), .cmp_hi_o(c_hi), .cmp_lo_o(c_lo)
  );

  picond_top i_picond_top (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .mode_wr_i(mode_wr_i), .mode_val_i(mode_val_i),
    .cfg_wr_i(cfg_wr_i), .cfg_port_i(cfg_port_i), .cfg_data_i(cfg_data_i),
    .pin_cmp_ttl_i(c_ttl), .pin_cmp_cmos_i(c_cmos), .pin_cmp_hi_i(c_hi), .pin_cmp_lo_i(c_lo),
    .mode_o(mode_o), .dir_o(dir_o), .level_sel_o(level_sel_o), .hyst_sel_o(hyst_sel_o),
    .edge_pol_o(edge_pol_o), .wakeup_en_o(wakeup_en_o), .edge_pend_o(edge_pend_o),
    .swap_data_o(swap_data_o), .swap_valid_o(swap_valid_o), .wake_req_o(wake_req_o),
    .pin_val_o(pin_val_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks

  // compare and count; widest value is 40 bits
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // software always sets the mode before the port write
  task automatic set_mode(input logic [3:0] m);
    @(posedge core_clk_i);
    mode_wr_i  <= 1'b1;
    mode_val_i <= m;
    @(posedge core_clk_i);
    mode_wr_i  <= 1'b0;
    #1;
    check(40'(mode_o), 40'(m));
  endtask

  // one port configuration write, results settled on return
  task automatic cfg(input logic [2:0] p, input logic [7:0] d);
    @(posedge core_clk_i);
    cfg_wr_i   <= 1'b1;
    cfg_port_i <= p;
    cfg_data_i <= d;
    @(posedge core_clk_i);
    cfg_wr_i   <= 1'b0;
    #1;
  endtask

  // move one pad, then wait past sync, value flop and edge flag
  task automatic pin(input int idx, input logic [6:0] v);
    @(posedge core_clk_i);
    volt[idx] <= v;
    repeat (5) @(posedge core_clk_i);
    #1;
  endtask

  task automatic final_report;
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios

  task automatic t_reset;
    check(40'(mode_o), 40'h0f);
    check(dir_o, 40'hff_ffff_ffff);
    check(level_sel_o, 40'hff_ffff_ffff);
    check(hyst_sel_o, 40'hff_ffff_ffff);
    check({edge_pol_o, edge_pend_o, swap_data_o}, 40'hff_0000);
    check({swap_valid_o, wake_req_o}, 40'h0);
    check(40'(wakeup_en_o), 40'hff);
  endtask

  // untouched detector still flags a falling edge and keeps it
  task automatic t_edge_default;
    pin(9, 7'd90);
    check(40'(pin_val_o[9]), 40'h1);
    check(40'(edge_pend_o), 40'h00);
    pin(9, 7'd0);
    check(40'(edge_pend_o), 40'h02);
    pin(9, 7'd90);
    pin(9, 7'd0);
    check(40'(edge_pend_o), 40'h02);
  endtask

  // swap out, then service one flag and write the rest back
  task automatic t_swap;
    set_mode(picond_pkg::MODE_SWAP);
    cfg(3'h1, 8'h00);
    check({swap_valid_o, swap_data_o, edge_pend_o}, 40'h1_02_00);
    pin(10, 7'd90);
    pin(10, 7'd0);
    pin(9, 7'd90);
    pin(9, 7'd0);
    cfg(3'h1, 8'h00);
    check(40'(swap_data_o), 40'h06);
    cfg(3'h1, 8'h06 & ~8'h02);
    check({swap_data_o, edge_pend_o}, 40'h00_04);
    cfg(3'h1, 8'h00);
    check({swap_data_o, edge_pend_o}, 40'h04_00);
  endtask

  // rising selection on bit 2 only; other ports refuse this mode
  task automatic t_polarity;
    set_mode(picond_pkg::MODE_EDGE);
    cfg(3'h1, 8'hfb);
    cfg(3'h2, 8'h00);
    check(40'(edge_pol_o), 40'hfb);
    pin(10, 7'd90);
    check(40'(edge_pend_o), 40'h04);
    pin(10, 7'd0);
    check(40'(edge_pend_o), 40'h04);
    set_mode(picond_pkg::MODE_SWAP);
    cfg(3'h1, 8'h00);
    check(40'(swap_data_o), 40'h04);
  endtask

  // only the enabled pin raises the wake request
  task automatic t_wake;
    set_mode(picond_pkg::MODE_WKEN);
    cfg(3'h1, 8'hfe);
    check(40'(wakeup_en_o), 40'hfe);
    pin(9, 7'd90);
    pin(9, 7'd0);
    check({edge_pend_o, 7'h0, wake_req_o}, 40'h02_00);
    pin(8, 7'd90);
    pin(8, 7'd0);
    check({edge_pend_o, 7'h0, wake_req_o}, 40'h03_01);
    set_mode(picond_pkg::MODE_SWAP);
    cfg(3'h1, 8'h00);
    check(40'(wake_req_o), 40'h0);
  endtask

  // port a keeps its upper nibble; threshold matters only on inputs
  task automatic t_level;
    set_mode(picond_pkg::MODE_LVL);
    cfg(3'h0, 8'h00);
    cfg(3'h2, 8'h0f);
    check(level_sel_o, 40'hff_ff_0f_ff_f0);
    cfg(3'h1, 8'h3c);
    check(40'(level_sel_o[15:8]), 40'h3c);
    pin(16, 7'd40);
    pin(20, 7'd40);
    check(40'(pin_val_o[20:16]), 40'h01);
    set_mode(picond_pkg::MODE_DIR);
    cfg(3'h2, 8'hfe);
    check(40'(dir_o[23:16]), 40'hfe);
    repeat (4) @(posedge core_clk_i);
    #1;
    check(40'(pin_val_o[16]), 40'h0);
    set_mode(picond_pkg::MODE_LVL);
    cfg(3'h2, 8'h0e);
    check(40'(level_sel_o[23:16]), 40'h0e);
  endtask

  // hysteresis on port d pin 0; 50 percent would read high through ttl
  task automatic t_hyst;
    logic [6:0] v [7] = '{7'd50, 7'd90, 7'd50, 7'd20, 7'd10, 7'd50, 7'd90};
    logic       e [7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    set_mode(picond_pkg::MODE_HYST);
    cfg(3'h0, 8'h00);
    cfg(3'h3, 8'h00);
    cfg(3'h1, 8'hf0);
    check(hyst_sel_o, 40'hff_00_ff_f0_ff);
    for (int k = 0; k < 7; k++) begin
      pin(24, v[k]);
      check(40'(pin_val_o[24]), 40'(e[k]));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog

  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1;
    t_reset();
    t_edge_default();
    t_swap();
    t_polarity();
    t_wake();
    t_level();
    t_hyst();
    final_report();
  end

  // the run needs well under a thousand cycles; allow twenty thousand
  initial begin
    repeat (20000) @(posedge core_clk_i);
    mismatches++;
    final_report();
  end
endmodule

// ---- src/picond_pin_cond.sv ----
// port-input constants and the per-pin input conditioning cell
`timescale 1ns/10ps
package picond_pkg;
  localparam int          NPORT     = 5;        // ports a to e
  localparam int          PW        = 8;        // pin bits per port register
  localparam int          NPIN      = NPORT * PW;
  localparam int          PA_PINS   = 4;        // port a only has bits 0-3
  localparam int          PB_LSB    = 8;        // port b position in the flat pin vectors
  localparam int          NCMP      = 4;        // comparator taps per pin
  localparam int          CMP_TTL   = 0;        // above ttl threshold
  localparam int          CMP_CMOS  = 1;        // above half supply
  localparam int          CMP_HI    = 2;        // above upper hysteresis threshold
  localparam int          CMP_LO    = 3;        // above lower hysteresis threshold
  localparam logic [2:0]  PORT_A    = 3'h0;
  localparam logic [2:0]  PORT_B    = 3'h1;
  localparam logic [3:0]  MODE_DIR  = 4'hf;     // direction registers, reset choice
  localparam logic [3:0]  MODE_PULL = 4'he;     // pull-ups, handled outside this block
  localparam logic [3:0]  MODE_LVL  = 4'hd;
  localparam logic [3:0]  MODE_HYST = 4'hc;
  localparam logic [3:0]  MODE_WKEN = 4'hb;
  localparam logic [3:0]  MODE_EDGE = 4'ha;
  localparam logic [3:0]  MODE_SWAP = 4'h9;
  localparam logic [3:0]  MODE_RST  = MODE_DIR;
  localparam logic [7:0]  REG_ONES  = 8'hff;    // reset of dir, level, hysteresis, edge, wake enable
  localparam logic [7:0]  PA_MASK   = 8'h0f;    // writable bits of port a
  localparam logic [7:0]  PEND_RST  = 8'h00;
  localparam logic [7:0]  SWAP_RST  = 8'h00;
endpackage

////////////////////////////////////////////////////////////////////////////////

module picond_pin_cond #(
  parameter bit HAS_HYST = 1'b1                          // port a pins have no hysteresis option
) (
  input  wire logic                            core_clk_i,  // system clock
  input  wire logic                            rst_i,       // async reset, active high
  input  wire logic [picond_pkg::NCMP-1:0]     cmp_i,       // raw comparator taps from the pad
  input  wire logic                            ttl_sel_i,   // 1 ttl, 0 cmos threshold
  input  wire logic                            norm_sel_i,  // 1 normal, 0 hysteresis input
  input  wire logic                            is_input_i,  // pin direction is input
  output logic                                 val_o        // interpreted pin level
);
  typedef struct packed {
    logic [picond_pkg::NCMP-1:0] sync1;
    logic [picond_pkg::NCMP-1:0] sync2;
    logic                        val;
  } picond_cell_t;

  picond_cell_t q;
  picond_cell_t d;

  // two stages on every tap: pads are asynchronous to the core clock
  always_comb begin
    d       = q;
    d.sync1 = cmp_i;
    d.sync2 = q.sync1;
    if (!is_input_i) begin
      d.val = q.sync2[picond_pkg::CMP_CMOS];              // selections have no effect on outputs
    end else if (HAS_HYST && !norm_sel_i) begin
      if (q.sync2[picond_pkg::CMP_HI]) begin
        d.val = 1'b1;                                     // crossed above upper threshold
      end else if (!q.sync2[picond_pkg::CMP_LO]) begin
        d.val = 1'b0;                                     // crossed below lower threshold
      end else begin
        d.val = q.val;                                    // in the band, hold last level
      end
    end else begin
      d.val = ttl_sel_i ? q.sync2[picond_pkg::CMP_TTL]    // threshold select per pin
                        : q.sync2[picond_pkg::CMP_CMOS];
    end
  end

  // single state register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign val_o = q.val;
endmodule

// ---- src/picond_top.sv ----
// port input conditioning, configuration registers and port b edge detection
//
// How it works
// - every pin has a threshold select bit; reset selects ttl everywhere.
// - mode d config write loads level register; 1 ttl, 0 cmos.
// - port a has pins 0-3 only; other ports have eight.
// - level writes always accepted, hysteresis writes on ports b-e only; both effective only on input pins.
// - hysteresis only on ports b-e; reset selects normal input.
// - mode c config write loads hysteresis register; 1 normal, 0 hysteresis.
// - hysteresis pin goes 1 above upper, 0 below lower, else holds.
// - each port b pin has edge select; reset selects falling edge.
// - mode a config write loads edge select; 1 falling, 0 rising.
// - selected edge on a port b pin sets its pending bit.
// - pending bits stay set until software writes them zero.
// - edge detection runs always, configured or not.
// - mode 9 port b write swaps old pending out and written value in.
// - an edge wakes the device only where wake-up is enabled.
// - config writes go where mode points; mode resets to f.
// - direction bit 1 is input, 0 output; all inputs after reset.
`timescale 1ns/10ps

module picond_top (
  input  wire logic                            core_clk_i,      // 25 MHz system clock
  input  wire logic                            rst_i,           // async reset, active high
  input  wire logic                            mode_wr_i,       // load the mode selector, one cycle
  input  wire logic [3:0]                      mode_val_i,      // new mode selector value
  input  wire logic                            cfg_wr_i,        // port configuration write, one cycle
  input  wire logic [2:0]                      cfg_port_i,      // target port, 0 = a ... 4 = e
  input  wire logic [7:0]                      cfg_data_i,      // written value (working register)
  input  wire logic [picond_pkg::NPIN-1:0]     pin_cmp_ttl_i,   // pad above ttl threshold
  input  wire logic [picond_pkg::NPIN-1:0]     pin_cmp_cmos_i,  // pad above half supply
  input  wire logic [picond_pkg::NPIN-1:0]     pin_cmp_hi_i,    // pad above upper hysteresis level
  input  wire logic [picond_pkg::NPIN-1:0]     pin_cmp_lo_i,    // pad above lower hysteresis level
  output logic [3:0]                           mode_o,          // current mode selector
  output logic [picond_pkg::NPIN-1:0]          dir_o,           // 1 input, 0 output
  output logic [picond_pkg::NPIN-1:0]          level_sel_o,     // 1 ttl, 0 cmos
  output logic [picond_pkg::NPIN-1:0]          hyst_sel_o,      // 1 normal, 0 hysteresis
  output logic [7:0]                           edge_pol_o,      // port b, 1 falling, 0 rising
  output logic [7:0]                           wakeup_en_o,     // port b, 0 enables wake-up
  output logic [7:0]                           edge_pend_o,     // port b sticky edge flags
  output logic [7:0]                           swap_data_o,     // old pending flags after a swap
  output logic                                 swap_valid_o,    // swap_data_o fresh, one cycle
  output logic                                 wake_req_o,      // enabled edge pending
  output logic [picond_pkg::NPIN-1:0]          pin_val_o        // conditioned pin levels
);
  typedef struct packed {
    logic [3:0]                  mode;
    logic [picond_pkg::NPIN-1:0] dir;
    logic [picond_pkg::NPIN-1:0] lvl;
    logic [picond_pkg::NPIN-1:0] hyst;
    logic [7:0]                  epol;
    logic [7:0]                  wken;
    logic [7:0]                  pend;
    logic [7:0]                  prev;
    logic [7:0]                  swap_data;
    logic                        swap_valid;
    logic                        wake;
  } picond_state_t;

  picond_state_t q;
  picond_state_t d;

  logic [picond_pkg::NPIN-1:0] pin_val;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // write only the bits the port really has
  function automatic logic [7:0] picond_merge(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic [7:0] mask);
    picond_merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // port a exposes four pins, the rest eight
  function automatic logic [7:0] picond_port_mask(input int unsigned p);
    picond_port_mask = (p == 0) ? picond_pkg::PA_MASK : picond_pkg::REG_ONES;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // per-pin conditioning; port a upper half has no pad and reads zero

  genvar gp;
  generate
    for (gp = 0; gp < picond_pkg::NPIN; gp++) begin : g_pin
      if ((gp < picond_pkg::PW) && ((gp % picond_pkg::PW) >= picond_pkg::PA_PINS)) begin : g_none
        assign pin_val[gp] = 1'b0;
      end else begin : g_cell
        picond_pin_cond #(
          .HAS_HYST (gp >= picond_pkg::PW)
        ) u_cond (
          .core_clk_i (core_clk_i),
          .rst_i      (rst_i),
          .cmp_i      ({pin_cmp_lo_i[gp], pin_cmp_hi_i[gp], pin_cmp_cmos_i[gp], pin_cmp_ttl_i[gp]}),
          .ttl_sel_i  (q.lvl[gp]),
          .norm_sel_i (q.hyst[gp]),
          .is_input_i (q.dir[gp]),
          .val_o      (pin_val[gp])
        );
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // next state

  logic [7:0] pend_base;
  logic [7:0] wmask;
  logic [7:0] cur_b;
  logic [7:0] edge_hit;

  // a mode write and a config write in one cycle: the config uses the old mode
  always_comb begin
    pend_base    = q.pend;
    wmask        = '0;
    cur_b        = pin_val[picond_pkg::PB_LSB +: picond_pkg::PW];
    edge_hit     = '0;
    d            = q;
    d.swap_valid = 1'b0;
    if (mode_wr_i) begin
      d.mode = mode_val_i;
    end
    for (int p = 0; p < picond_pkg::NPORT; p++) begin
      if (cfg_wr_i && (cfg_port_i == 3'(p))) begin
        wmask = picond_port_mask(p);
        case (q.mode)                                                // target chosen by mode
          picond_pkg::MODE_DIR: begin
            d.dir[p*8 +: 8] = picond_merge(q.dir[p*8 +: 8], cfg_data_i, wmask);
          end
          picond_pkg::MODE_LVL: begin
            d.lvl[p*8 +: 8] = picond_merge(q.lvl[p*8 +: 8], cfg_data_i, wmask);
          end
          picond_pkg::MODE_HYST: begin
            if (p != 0) begin
              d.hyst[p*8 +: 8] = cfg_data_i;
            end
          end
          picond_pkg::MODE_WKEN: begin
            if (p == 1) begin
              d.wken = cfg_data_i;
            end
          end
          picond_pkg::MODE_EDGE: begin
            if (p == 1) begin
              d.epol = cfg_data_i;
            end
          end
          picond_pkg::MODE_SWAP: begin
            if (p == 1) begin
              d.swap_data  = q.pend;                                 // old flags out
              d.swap_valid = 1'b1;
              pend_base    = cfg_data_i;                             // written value
            end
          end
          default: begin
            // pull-ups and unused modes: nothing held here
          end
        endcase
      end
    end
    // edge detector never gated by configuration; a hit beats a same-cycle clear
    edge_hit = (q.epol & q.prev & ~cur_b) | (~q.epol & ~q.prev & cur_b);
    d.prev   = cur_b;
    d.pend   = pend_base | edge_hit;                                 // set only, never self-cleared
    d.wake   = |(d.pend & ~d.wken);                                  // wake-up only where enabled
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q.mode       <= picond_pkg::MODE_RST;
      q.dir        <= {picond_pkg::NPORT{picond_pkg::REG_ONES}};     // all inputs
      q.lvl        <= {picond_pkg::NPORT{picond_pkg::REG_ONES}};     // all ttl
      q.hyst       <= {picond_pkg::NPORT{picond_pkg::REG_ONES}};     // all normal
      q.epol       <= picond_pkg::REG_ONES;                          // falling edges
      q.wken       <= picond_pkg::REG_ONES;                          // wake-up disabled
      q.pend       <= picond_pkg::PEND_RST;
      q.prev       <= '0;
      q.swap_data  <= picond_pkg::SWAP_RST;
      q.swap_valid <= 1'b0;
      q.wake       <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state flops
  assign mode_o       = q.mode;
  assign dir_o        = q.dir;
  assign level_sel_o  = q.lvl;
  assign hyst_sel_o   = q.hyst;
  assign edge_pol_o   = q.epol;
  assign wakeup_en_o  = q.wken;
  assign edge_pend_o  = q.pend;
  assign swap_data_o  = q.swap_data;
  assign swap_valid_o = q.swap_valid;
  assign wake_req_o   = q.wake;
  assign pin_val_o    = pin_val;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_cfg_b(logic [3:0] m);
    cfg_wr_i && (cfg_port_i == picond_pkg::PORT_B) && (mode_o == m);
  endsequence

  sequence s_no_swap;
    !(cfg_wr_i && (cfg_port_i == picond_pkg::PORT_B) && (mode_o == picond_pkg::MODE_SWAP));
  endsequence

  a_mode_load: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mode_wr_i |=> (mode_o == $past(mode_val_i)))
    else $error("mode selector did not take the written value");

  a_level_load: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_cfg_b(picond_pkg::MODE_LVL) |=> (level_sel_o[15:8] == $past(cfg_data_i)))
    else $error("level register of port b not loaded");

  a_porta_width: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cfg_wr_i && (cfg_port_i == picond_pkg::PORT_A)) |=>
      ((dir_o[7:4] == 4'hf) && (level_sel_o[7:4] == 4'hf) && (pin_val_o[7:4] == 4'h0)))
    else $error("port a upper bits changed");

  a_hyst_load: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_cfg_b(picond_pkg::MODE_HYST) |=> (hyst_sel_o[15:8] == $past(cfg_data_i)))
    else $error("hysteresis register of port b not loaded");

  a_porta_nohyst: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cfg_wr_i && (mode_o == picond_pkg::MODE_HYST)) |=> (hyst_sel_o[7:0] == 8'hff))
    else $error("port a took a hysteresis selection");

  a_edge_load: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_cfg_b(picond_pkg::MODE_EDGE) |=> (edge_pol_o == $past(cfg_data_i)))
    else $error("edge select register not loaded");

  a_swap_out: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_cfg_b(picond_pkg::MODE_SWAP) |=>
      (swap_valid_o && (swap_data_o == $past(edge_pend_o)) &&
       ((edge_pend_o & $past(cfg_data_i)) == $past(cfg_data_i))))
    else $error("swap did not exchange pending flags");

  a_pend_sticky: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_no_swap |=> ((edge_pend_o & $past(edge_pend_o)) == $past(edge_pend_o)))
    else $error("pending flag cleared without a swap");

  a_edge_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
    1'b1 ##1 1'b1 |=>
      ((edge_pend_o & ($past(edge_pol_o & ~pin_val_o[15:8]) & $past(pin_val_o[15:8], 2))) ==
       ($past(edge_pol_o & ~pin_val_o[15:8]) & $past(pin_val_o[15:8], 2))))
    else $error("falling edge not flagged");

  a_wake_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wake_req_o |-> (|(edge_pend_o & ~wakeup_en_o)))
    else $error("wake request without an enabled pending edge");

  // one port write step: the target is picked by the mode seen on that edge
  sequence s_cfg(logic [2:0] p, logic [3:0] m);
    cfg_wr_i && (cfg_port_i == p) && (mode_o == m);
  endsequence

  // direction registers
  a_dir_load: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_cfg(picond_pkg::PORT_B, picond_pkg::MODE_DIR) |=> (dir_o[15:8] == $past(cfg_data_i)))
    else $error("direction register of port b not loaded");

  a_dir_porta: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_cfg(picond_pkg::PORT_A, picond_pkg::MODE_DIR) |=> (dir_o[3:0] == $past(cfg_data_i[3:0])))
    else $error("direction register of port a not loaded");

  a_dir_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(cfg_wr_i && (mode_o == picond_pkg::MODE_DIR)) |=> $stable(dir_o))
    else $error("direction changed without a direction write");

  // level and hysteresis selections move only on their own mode
  a_level_porta: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_cfg(picond_pkg::PORT_A, picond_pkg::MODE_LVL) |=> (level_sel_o[3:0] == $past(cfg_data_i[3:0])))
    else $error("level register of port a not loaded");

  a_level_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(cfg_wr_i && (mode_o == picond_pkg::MODE_LVL)) |=> $stable(level_sel_o))
    else $error("level selection changed without a level write");

  a_hyst_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(cfg_wr_i && (mode_o == picond_pkg::MODE_HYST)) |=> $stable(hyst_sel_o))
    else $error("hysteresis selection changed without a hysteresis write");

  // edge select and wake enable exist on port b only
  a_edge_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(cfg_wr_i && (cfg_port_i == picond_pkg::PORT_B) && (mode_o == picond_pkg::MODE_EDGE)) |=>
      $stable(edge_pol_o))
    else $error("edge select changed without a port b edge write");

  a_wken_load: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_cfg(picond_pkg::PORT_B, picond_pkg::MODE_WKEN) |=> (wakeup_en_o == $past(cfg_data_i)))
    else $error("wake enable register not loaded");

  a_wken_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(cfg_wr_i && (cfg_port_i == picond_pkg::PORT_B) && (mode_o == picond_pkg::MODE_WKEN)) |=>
      $stable(wakeup_en_o))
    else $error("wake enable changed without a port b wake write");

  a_wken_porta: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_cfg(picond_pkg::PORT_A, picond_pkg::MODE_WKEN) |=> $stable(wakeup_en_o))
    else $error("port a write reached the wake enable register");

  // mode selector
  a_mode_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !mode_wr_i |=> $stable(mode_o))
    else $error("mode selector changed without a mode write");

  // swap output: a pulse per swap, data kept until the next one
  a_swap_pulse: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_no_swap |=> !swap_valid_o)
    else $error("swap valid without a swap write");

  a_swap_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_no_swap |=> $stable(swap_data_o))
    else $error("swap data changed without a swap write");

  a_swap_porta: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_cfg(picond_pkg::PORT_A, picond_pkg::MODE_SWAP) |=> $stable(swap_data_o))
    else $error("port a write started a swap");

  // pending flags: rising selections flag, and nothing but an edge or a port b swap write sets a flag
  a_edge_rise: assert property (@(posedge core_clk_i) disable iff (rst_i)
    1'b1 ##1 1'b1 |=>
      ((edge_pend_o & $past(~edge_pol_o & pin_val_o[15:8]) & ~$past(pin_val_o[15:8], 2)) ==
       ($past(~edge_pol_o & pin_val_o[15:8]) & ~$past(pin_val_o[15:8], 2))))
    else $error("rising edge not flagged");

  a_pend_cause: assert property (@(posedge core_clk_i) disable iff (rst_i)
    1'b1 ##1 s_no_swap |=>
      ((edge_pend_o & ~$past(edge_pend_o) &
        ~(($past(edge_pol_o & ~pin_val_o[15:8]) & $past(pin_val_o[15:8], 2)) |
          ($past(~edge_pol_o & pin_val_o[15:8]) & ~$past(pin_val_o[15:8], 2)))) == 8'h00))
    else $error("pending flag set without a selected edge");

  // wake request follows every enabled pending flag
  a_wake_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (|(edge_pend_o & ~wakeup_en_o)) |-> wake_req_o)
    else $error("enabled pending edge without a wake request");

  // port a upper nibble has no pins at any time
  a_porta_fixed: assert property (@(posedge core_clk_i) disable iff (rst_i)
    1'b1 |-> ((dir_o[7:4] == 4'hf) && (level_sel_o[7:4] == 4'hf) && (pin_val_o[7:4] == 4'h0)))
    else $error("port a upper bits not fixed");

endmodule
